// ---- sim/bsp_peer.sv ----
// remote serial peer: idle-high line, rts-paced data, cts from the bench
`timescale 1ns/1ps
module bsp_peer (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic txd,
  input  wire logic rts_n,
  input  wire logic busy,
  output logic      rxd,
  output logic      cts_n
);
  ////////////////////////////////////////////////////////////////////////////
  // sends a changing pattern only while the channel asks for data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd   <= 1'b1;
      cts_n <= 1'b1;
    end else begin
      rxd   <= rts_n ? 1'b1 : ~rxd;
      cts_n <= busy;
    end
  end
endmodule : bsp_peer

// ---- sim/test_bsp_chan.sv ----
// self-checking bench of the fifo control and count channel
`timescale 1ns/1ps
module test_bsp_chan;
  import bsp_pkg::*;
  logic              clk, rst_n, wr, rd, sync_mode, ser_txd, tx_pop, rx_push;
  logic              peer_busy, irq, ser_rxd, txd, rxd, cts_n, rts_n;
  logic              ser_cts_n, tx_valid, r;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, rdata_nf, e;
  logic [BYTE_W-1:0] tx_data, rx_push_data, b;
  logic [7:0]        txq[$], rxq[$];
  logic [31:0]       seed = 32'h1E626B6B;
  int                n_fail, checks;
  wire  [5:0]        pins = {txd, ser_rxd, rts_n, ser_cts_n, tx_valid, irq};

  bsp_chan #(.HAS_FLOW(1'b1), .DEPTH(FIFO_DEPTH)) dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .sync_mode(sync_mode), .ser_txd(ser_txd),
    .ser_rxd(ser_rxd), .txd(txd), .rxd(rxd), .cts_n(cts_n), .rts_n(rts_n),
    .ser_cts_n(ser_cts_n), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_pop(tx_pop), .rx_push(rx_push), .rx_push_data(rx_push_data));
  bsp_peer peer (.clk(clk), .rst_n(rst_n), .txd(txd), .rts_n(rts_n),
    .busy(peer_busy), .rxd(rxd), .cts_n(cts_n));
  // second channel without flow control, sharing the register bus
  bsp_chan #(.HAS_FLOW(1'b0), .DEPTH(4)) dut_nf (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata_nf), .irq(), .sync_mode(sync_mode), .ser_txd(ser_txd),
    .ser_rxd(), .txd(), .rxd(rxd), .cts_n(cts_n), .rts_n(),
    .ser_cts_n(), .tx_data(), .tx_valid(), .tx_pop(tx_pop),
    .rx_push(rx_push), .rx_push_data(rx_push_data));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [15:0] cw();
    return {3'h0, 5'(txq.size()), 3'h0, 5'(rxq.size())};
  endfunction : cw
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wreg(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wreg
  task automatic rchk(logic [3:0] a, logic [15:0] x, string nm);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(nm, rdata, x);
  endtask : rchk
  task automatic rxp(logic [7:0] d);
    @(posedge clk);
    rx_push      <= 1'b1;
    rx_push_data <= d;
    @(posedge clk);
    rx_push      <= 1'b0;
  endtask : rxp
  task automatic txp();
    @(posedge clk);
    tx_pop <= 1'b1;
    @(posedge clk);
    tx_pop <= 1'b0;
    #1;
  endtask : txp

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {wr, rd, sync_mode, tx_pop, rx_push, peer_busy} = '0;
    addr = '0;
    wdata = '0;
    rx_push_data = '0;
    ser_txd = 1'b1;
    n_fail = 0;
    checks = 0;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    chk("pins", {10'h0, pins}, 16'h0030);
    rst_n <= 1'b1;
    rchk(OFS_CTRL, 16'h0000, "ctrl");
    rchk(OFS_COUNT, 16'h0000, "count");
    wreg(OFS_COUNT, 16'h1F1F);
    rchk(OFS_COUNT, 16'h0000, "count ro");
    rchk(4'hF, 16'h0000, "unmapped");
    // one push beyond full must be dropped
    for (int i = 0; i < 17; i++) begin
      b = 8'(rnd());
      wreg(OFS_TXQ, {8'h00, b});
      if (txq.size() < FIFO_DEPTH) txq.push_back(b);
    end
    rchk(OFS_COUNT, cw(), "count tx full");
    wreg(OFS_STAT, 16'h0007);
    for (int i = 0; i < 8; i++) begin
      if (i == 7) rchk(OFS_STAT, 16'h0000, "stat tx 9");
      e = {8'h01, txq.pop_front()};
      chk("tx head", {7'h0, tx_valid, tx_data}, e);
      txp();
    end
    rchk(OFS_STAT, 16'h0002, "stat tx 8");
    rchk(OFS_COUNT, cw(), "count tx pop");
    wreg(OFS_MASK, 16'h0002);
    tick();
    chk("irq on", {15'h0, irq}, 16'h0001);
    wreg(OFS_MASK, 16'h0000);
    tick();
    chk("irq off", {15'h0, irq}, 16'h0000);
    // flush holds the queue empty even against a write
    wreg(OFS_CTRL, 16'h0004);
    wreg(OFS_TXQ, 16'h00A5);
    txq.delete();
    rchk(OFS_COUNT, cw(), "tx flush");
    chk("tx valid", {15'h0, tx_valid}, 16'h0000);
    wreg(OFS_CTRL, 16'h0008);
    rchk(OFS_CTRL, 16'h0008, "ctrl flow");
    chk("ctrl no flow", rdata_nf, 16'h0000);
    for (int i = 0; i < 17; i++) begin
      b = 8'(rnd());
      rxp(b);
      if (rxq.size() < FIFO_DEPTH) rxq.push_back(b);
    end
    rchk(OFS_COUNT, cw(), "count rx full");
    chk("rts full", {15'h0, rts_n}, 16'h0001);
    rchk(OFS_STAT, 16'h0007, "stat rx");
    repeat (2) rchk(OFS_RXQ, {8'h00, rxq.pop_front()}, "rx data");
    tick();
    chk("rts low", {15'h0, rts_n}, 16'h0000);
    @(posedge clk);
    peer_busy <= 1'b1;
    repeat (2) tick();
    chk("cts on", {15'h0, ser_cts_n}, 16'h0001);
    wreg(OFS_CTRL, 16'h0000);
    repeat (2) begin
      b = 8'(rnd());
      rxp(b);
      rxq.push_back(b);
    end
    tick();
    chk("flow off", {14'h0, rts_n, ser_cts_n}, 16'h0000);
    r = rxd;
    tick();
    chk("rxd path", {15'h0, ser_rxd}, {15'h0, r});
    wreg(OFS_CTRL, 16'h0002);
    rxp(8'h3C);
    rxq.delete();
    rchk(OFS_COUNT, cw(), "rx flush");
    // clocked mode: flow control kept off, rx trigger 01 selects 2
    @(posedge clk);
    sync_mode <= 1'b1;
    wreg(OFS_CTRL, 16'h0040);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) begin
        wreg(OFS_STAT, 16'h0007);
        rchk(OFS_STAT, 16'h0002, "stat sync 2");
      end
      b = 8'(rnd());
      rxp(b);
      rxq.push_back(b);
    end
    rchk(OFS_STAT, 16'h0003, "stat sync 3");
    rchk(OFS_COUNT, cw(), "count sync");
    wreg(OFS_CTRL, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      b = 8'(rnd());
      @(posedge clk);
      ser_txd <= b[0];
      tick();
      chk("loop", {14'h0, txd, ser_rxd}, {15'h1, b[0]});
    end
    wrap_up();
  end
endmodule : test_bsp_chan

// ---- src/bsp_chan.sv ----
// fifo control, occupancy count, flow control and loop-back of one channel
`timescale 1ns/1ps
module bsp_chan #(
  parameter bit HAS_FLOW = 1'b1,
  parameter int DEPTH    = 16
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [bsp_pkg::ADDR_W-1:0] addr,
  input  wire logic [bsp_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [bsp_pkg::DATA_W-1:0] rdata,
  output logic                            irq,
  input  wire logic                       sync_mode,
  input  wire logic                       ser_txd,
  output logic                            ser_rxd,
  output logic                            txd,
  input  wire logic                       rxd,
  input  wire logic                       cts_n,
  output logic                            rts_n,
  output logic                            ser_cts_n,
  output logic      [bsp_pkg::BYTE_W-1:0] tx_data,
  output logic                            tx_valid,
  input  wire logic                       tx_pop,
  input  wire logic                       rx_push,
  input  wire logic [bsp_pkg::BYTE_W-1:0] rx_push_data
);
  import bsp_pkg::*;

  if (DEPTH < 2 || DEPTH > FIFO_DEPTH || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("bsp_chan: DEPTH must be a power of two from 2 to 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger decoding
  function automatic logic [CNT_W-1:0] rx_trig_of(input logic [1:0] sel,
                                                   input logic       syn);
    case (sel)
      2'b00:   rx_trig_of = RT_A0;
      2'b01:   rx_trig_of = syn ? RT_S1 : RT_A1;
      2'b10:   rx_trig_of = RT_2;
      default: rx_trig_of = RT_3;
    endcase
  endfunction : rx_trig_of

  function automatic logic [CNT_W-1:0] tx_trig_of(input logic [1:0] sel);
    case (sel)
      2'b00:   tx_trig_of = TT_0;
      2'b01:   tx_trig_of = TT_1;
      2'b10:   tx_trig_of = TT_2;
      default: tx_trig_of = TT_3;
    endcase
  endfunction : tx_trig_of

  ////////////////////////////////////////////////////////////////////////////
  // registers and decode
  logic [7:0]       ctrl;
  logic [ST_W-1:0]  status;
  logic [ST_W-1:0]  mask;
  logic [CNT_W-1:0] tx_cnt;
  logic [CNT_W-1:0] rx_cnt;
  logic             tx_full;
  logic             rx_full;
  logic             rx_avail;
  logic [BYTE_W-1:0] rx_head;

  wire wr_ctrl = wr && addr == OFS_CTRL;
  wire wr_txq  = wr && addr == OFS_TXQ;
  wire wr_stat = wr && addr == OFS_STAT;
  wire wr_mask = wr && addr == OFS_MASK;
  wire rd_rxq  = rd && addr == OFS_RXQ;

  wire flow_en  = ctrl[B_FLOW];
  wire loop_en  = ctrl[B_LOOP];
  wire tx_flush = ctrl[B_TXFLUSH];
  wire rx_flush = ctrl[B_RXFLUSH];

  wire [CNT_W-1:0] rx_trig = rx_trig_of(ctrl[F_RTRG_LO+:2], sync_mode);
  wire [CNT_W-1:0] tx_trig = tx_trig_of(ctrl[F_TTRG_LO+:2]);

  // enable bit is not writable where flow control is absent
  wire [7:0] ctrl_wmask = HAS_FLOW ? CTRL_WMASK           // [RULE4]
                                   : (CTRL_WMASK & ~(8'h01 << B_FLOW));
  wire [7:0] next_ctrl  = wdata[7:0] & ctrl_wmask;

  // count register layout, reserved bits zero
  wire [DATA_W-1:0] count_word =
    {3'h0, tx_cnt, 3'h0, rx_cnt};                         // [RULE9] [RULE12]

  wire rx_lvl_hit = rx_cnt > rx_trig;                     // [RULE14]
  wire tx_low_hit = tx_cnt <= tx_trig;                    // [RULE15]
  wire ovrun_hit  = rx_push && rx_full && !rx_flush;

  wire [ST_W-1:0] set_bits = {ovrun_hit, tx_low_hit, rx_lvl_hit};
  wire [ST_W-1:0] clr_bits = wr_stat ? wdata[ST_W-1:0] : '0;
  // a set in the clearing cycle survives
  wire [ST_W-1:0] next_status = (status & ~clr_bits) | set_bits;

  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    case (addr)
      OFS_CTRL:  rd_mux = {8'h00, ctrl};
      OFS_COUNT: rd_mux = count_word;                     // [RULE10] [RULE11]
      OFS_RXQ:   rd_mux = {8'h00, rx_head};
      OFS_STAT:  rd_mux = {{(DATA_W-ST_W){1'b0}}, status};
      OFS_MASK:  rd_mux = {{(DATA_W-ST_W){1'b0}}, mask};
      default:   rd_mux = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl   <= CTRL_RST;                                 // [RULE7]
      status <= STAT_RST;
      mask   <= MASK_RST;
      rdata  <= '0;
      irq    <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl <= next_ctrl;
      if (wr_mask) mask <= wdata[ST_W-1:0];
      status <= next_status;
      rdata  <= rd ? rd_mux : '0;
      irq    <= |(next_status & mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifos
  bsp_fifo #(
    .W     (BYTE_W),
    .DEPTH (DEPTH),
    .CW    (CNT_W)
  ) u_txq (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (tx_flush),                                // [RULE5]
    .push      (wr_txq),                                  // [RULE16]
    .push_data (wdata[BYTE_W-1:0]),
    .pop       (tx_pop),
    .head      (tx_data),
    .count     (tx_cnt),
    .not_empty (tx_valid),
    .full      (tx_full)
  );

  bsp_fifo #(
    .W     (BYTE_W),
    .DEPTH (DEPTH),
    .CW    (CNT_W)
  ) u_rxq (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (rx_flush),                                // [RULE6]
    .push      (rx_push),                                 // [RULE16]
    .push_data (rx_push_data),
    .pop       (rd_rxq),
    .head      (rx_head),
    .count     (rx_cnt),
    .not_empty (rx_avail),
    .full      (rx_full)
  );

  ////////////////////////////////////////////////////////////////////////////
  // flow control and loop-back
  wire rts_int = flow_en && rx_cnt >= CNT_W'(RTS_LEVEL);  // [RULE1] [RULE2]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_cts_n <= 1'b0;
      rts_n     <= 1'b0;
      txd       <= 1'b1;
      ser_rxd   <= 1'b1;
    end else begin
      ser_cts_n <= flow_en ? cts_n : 1'b0;                // [RULE1] [RULE2]
      rts_n     <= rts_int;
      txd       <= loop_en ? 1'b1 : ser_txd;              // [RULE8]
      ser_rxd   <= loop_en ? ser_txd : rxd;               // [RULE8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_cts_forced_on: assert property ( // [RULE2]
    @(posedge clk) disable iff (!rst_n)
    !flow_en |=> ser_cts_n == 1'b0 && rts_n == 1'b0)
    else $error("cts not forced asserted with flow control off");

  a_cts_follows_pin: assert property ( // [RULE1]
    @(posedge clk) disable iff (!rst_n)
    flow_en |=> ser_cts_n == $past(cts_n))
    else $error("cts does not follow pin with flow control on");

  a_rts_hold_off: assert property ( // [RULE1]
    @(posedge clk) disable iff (!rst_n)
    flow_en && rx_cnt >= CNT_W'(RTS_LEVEL) |=> rts_n)
    else $error("rts not raised on nearly full receive fifo");

  a_no_flow_bit: assert property ( // [RULE4]
    @(posedge clk) disable iff (!rst_n)
    !HAS_FLOW |-> !flow_en)
    else $error("flow enable set on channel without flow control");

  a_tx_flush_empty: assert property ( // [RULE5]
    @(posedge clk) disable iff (!rst_n)
    tx_flush |=> tx_cnt == '0 && !tx_valid)
    else $error("transmit fifo not empty after flush");

  a_rx_flush_empty: assert property ( // [RULE6]
    @(posedge clk) disable iff (!rst_n)
    rx_flush |=> rx_cnt == '0 && !rx_avail)
    else $error("receive fifo not empty after flush");

  a_reset_empty: assert property ( // [RULE7]
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> tx_cnt == '0 && rx_cnt == '0 && !tx_flush && !rx_flush)
    else $error("fifos or flush bits not cleared by reset");

  a_reset_count: assert property ( // [RULE13]
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> count_word == COUNT_RST)
    else $error("count register not zero after reset");

  a_loop_route: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
    loop_en |=> ser_rxd == $past(ser_txd) && txd)
    else $error("loop-back does not route transmit to receive");

  a_count_read: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
    rd && addr == OFS_COUNT |=> rdata[12:8] == $past(tx_cnt)
      && rdata[4:0] == $past(rx_cnt))
    else $error("count register read does not show occupancy");

  a_count_resv: assert property ( // [RULE12]
    @(posedge clk) disable iff (!rst_n)
    rd && addr == OFS_COUNT |=> rdata[15:13] == 3'h0 && rdata[7:5] == 3'h0)
    else $error("reserved count bits not zero");

  a_tx_count_max: assert property ( // [RULE10]
    @(posedge clk) disable iff (!rst_n)
    tx_cnt <= CNT_W'(DEPTH) && (tx_full == (tx_cnt == CNT_W'(DEPTH))))
    else $error("transmit count out of range");

  a_rx_count_max: assert property ( // [RULE11]
    @(posedge clk) disable iff (!rst_n)
    rx_cnt <= CNT_W'(DEPTH) && (rx_full == (rx_cnt == CNT_W'(DEPTH))))
    else $error("receive count out of range");

  a_rx_push_step: assert property ( // [RULE16]
    @(posedge clk) disable iff (!rst_n)
    rx_push && !rx_full && !rd_rxq && !rx_flush
      |=> rx_cnt == $past(rx_cnt) + CNT_W'(1))
    else $error("receive count did not step on push");

  a_tx_pop_step: assert property ( // [RULE16]
    @(posedge clk) disable iff (!rst_n)
    tx_pop && tx_valid && !wr_txq && !tx_flush
      |=> tx_cnt == $past(tx_cnt) - CNT_W'(1))
    else $error("transmit count did not step on pop");

  a_rx_level_flag: assert property ( // [RULE14]
    @(posedge clk) disable iff (!rst_n)
    rx_cnt > rx_trig |=> status[S_RXLVL])
    else $error("rx_level_reached not set above trigger");

  a_tx_level_flag: assert property ( // [RULE15]
    @(posedge clk) disable iff (!rst_n)
    tx_cnt <= tx_trig |=> status[S_TXLOW])
    else $error("tx_level_low not set at trigger");

  a_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 irq == |($past(next_status) & $past(mask)))
    else $error("interrupt does not follow masked status");
endmodule : bsp_chan

// ---- src/bsp_fifo.sv ----
// byte fifo with flush, occupancy count and registered flags
`timescale 1ns/1ps
module bsp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16,
  parameter int CW    = 5
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          flush,
  input  wire logic          push,
  input  wire logic [W-1:0]  push_data,
  input  wire logic          pop,
  output logic      [W-1:0]  head,
  output logic      [CW-1:0] count,
  output logic               not_empty,
  output logic               full
);
  localparam int PW = $clog2(DEPTH);
  localparam bit BAD_PARAM = DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0
                             || CW < $clog2(DEPTH + 1);

  if (BAD_PARAM) begin : g_bad_param
    $error("bsp_fifo: DEPTH must be a power of two that fits in CW");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] next_count;
  wire           do_push = push && !full && !flush;
  wire           do_pop  = pop && not_empty && !flush;

  assign head = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (flush)
      next_count = '0;
    else if (do_push && !do_pop)
      next_count = count + CW'(1);
    else if (do_pop && !do_push)
      next_count = count - CW'(1);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      not_empty <= 1'b0;
      full      <= 1'b0;
    end else begin
      wr_ptr    <= flush ? '0 : wr_ptr + PW'(do_push);
      rd_ptr    <= flush ? '0 : rd_ptr + PW'(do_pop);
      count     <= next_count;
      not_empty <= next_count != '0;
      full      <= next_count == CW'(DEPTH);
    end
  end

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end
endmodule : bsp_fifo

// ---- src/bsp_pkg.sv ----
// constants of the buffered serial port fifo control and count block
// What this block does
// RULE1 - flow_ctrl_enable set: use cts pin and drive rts as flow control
// RULE2 - flow control off: cts seen asserted (0), internal rts held 0
// RULE3 - software keeps flow_ctrl_enable clear in clocked synchronous mode
// RULE4 - channel without flow control: enable bit reads 0, write only 0
// RULE5 - while tx_queue_flush is 1, transmit fifo is held empty
// RULE6 - while rx_queue_flush is 1, receive fifo is held empty
// RULE7 - reset empties both fifos and clears both flush bits
// RULE8 - loop-back bit routes transmit output internally to receive input
// RULE9 - count register: tx occupancy high byte, rx low byte, readable
// RULE10 - bits 12..8 count tx entries, 0 when empty, 10h when full
// RULE11 - bits 4..0 count rx entries, 0 when empty, 10h when full
// RULE12 - count bits 15..13 and 7..5 read 0, software writes 0
// RULE13 - reset clears the whole count register to 0000h
// RULE14 - rx_level_reached set once rx occupancy exceeds rx trigger
// RULE15 - tx_level_low set once tx occupancy drops to the tx trigger
// RULE16 - counts step by one on each push or pop, one cycle later
package bsp_pkg;
  localparam int          ADDR_W     = 4;
  localparam int          DATA_W     = 16;
  localparam int          BYTE_W     = 8;
  localparam int          CNT_W      = 5;
  localparam int          FIFO_DEPTH = 16;
  localparam int          RTS_LEVEL  = 15;

  // register addresses
  localparam logic [3:0]  OFS_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_COUNT  = 4'h1;
  localparam logic [3:0]  OFS_TXQ    = 4'h2;
  localparam logic [3:0]  OFS_RXQ    = 4'h3;
  localparam logic [3:0]  OFS_STAT   = 4'h4;
  localparam logic [3:0]  OFS_MASK   = 4'h5;

  // fifo_control fields
  localparam int          B_LOOP     = 0;
  localparam int          B_RXFLUSH  = 1;
  localparam int          B_TXFLUSH  = 2;
  localparam int          B_FLOW     = 3;
  localparam int          F_TTRG_LO  = 4;
  localparam int          F_RTRG_LO  = 6;
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  CTRL_WMASK = 8'hFF;

  // fifo_occupancy_count fields
  localparam int          F_TXCNT_LO = 8;
  localparam int          F_RXCNT_LO = 0;
  localparam logic [15:0] COUNT_RST  = 16'h0000;

  // status and mask bits
  localparam int          ST_W       = 3;
  localparam int          S_RXLVL    = 0;
  localparam int          S_TXLOW    = 1;
  localparam int          S_OVRUN    = 2;
  localparam logic [2:0]  STAT_RST   = 3'h0;
  localparam logic [2:0]  MASK_RST   = 3'h0;

  // trigger levels
  localparam logic [4:0]  RT_A0 = 5'h01, RT_A1 = 5'h04;
  localparam logic [4:0]  RT_S1 = 5'h02, RT_2 = 5'h08, RT_3 = 5'h0E;
  localparam logic [4:0]  TT_0 = 5'h08, TT_1 = 5'h04;
  localparam logic [4:0]  TT_2 = 5'h02, TT_3 = 5'h00;
endpackage : bsp_pkg
